// File: core/tpc_crc.sv
// Purpose: byte-wise frame check sequence accumulator
// Assumes: init and en never both high
// Notes:   reflected crc-32, result is inverted by the caller
`timescale 1ns/1ps
module tpc_crc (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc_q
);
  import tpc_pkg::*;

  logic [31:0] crc_d;

  // ------------------------------------------------------------
  // next value: fold one byte, lsb first
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] c;
    c = crc_q;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ data[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    crc_d = crc_q;
    if (init) begin
      crc_d = CRC_INIT;
    end else if (en) begin
      crc_d = c;
    end
  end

  // register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      crc_q <= CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end
endmodule

// File: core/tpc_pkg.sv
// Purpose: shared constants and carrier types for the transmit path control block
// Assumes: one byte lane per core_clk cycle on both stream and line sides
// Notes:   line codes follow the usual 10G-style control character values
package tpc_pkg;
  // ------------------------------------------------------------
  // line codes
  // ------------------------------------------------------------
  localparam logic [7:0]  CODE_IDLE  = 8'h07;
  localparam logic [7:0]  CODE_START = 8'hFB;
  localparam logic [7:0]  CODE_TERM  = 8'hFD;
  localparam logic [7:0]  CODE_ERROR = 8'hFE;
  // ------------------------------------------------------------
  // gap, frame check and scrambler constants
  // ------------------------------------------------------------
  localparam logic [3:0]  IPG_MIN    = 4'h8;  // smallest setting that adds idles
  localparam logic [3:0]  IPG_MAX    = 4'hC;  // larger settings are clamped here
  localparam logic [3:0]  IPG_TERM   = 4'h1;  // bytes taken by the terminate code
  localparam logic [31:0] CRC_INIT   = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY   = 32'hEDB88320;
  localparam logic [1:0]  FCS_LAST   = 2'h3;  // index of the fourth fcs byte
  localparam logic [57:0] SCR_INIT   = 58'h3FFFFFFFFFFFFFF;
  localparam int          SCR_TAP_A  = 38;
  localparam int          SCR_TAP_B  = 57;

  // stream byte from user logic
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } tpc_beat_type;

  // one line byte: ctrl high means data holds a control code
  typedef struct packed {
    logic       ctrl;
    logic [7:0] data;
  } tpc_line_type;

  // transmit control inputs
  typedef struct packed {
    logic       test_pattern;
    logic       tx_gate;
    logic       fcs_append;
    logic [3:0] ipg_bytes;
  } tpc_ctl_type;
endpackage

// File: core/tpc_top.sv
// Purpose: transmit path control: gate, fcs append, gap and test pattern
// Assumes: control inputs come from logic on core_clk; source keeps valid within a packet
// Notes:   gate and fcs choice are taken only at a packet start; test mode is taken on every idle-state cycle
`timescale 1ns/1ps
// How it works
// - test pattern select high sends a scrambled idle pattern instead of traffic.
// - packets start only while the gate is high, and a started packet runs to its end; otherwise idles only.
// - fcs append high adds computed frame check bytes; low adds none.
// - gap setting 8 to 12 gives that many bytes between packets.
// - gap setting 0 to 7 gives only the terminate byte, no idles.
module tpc_top (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire tpc_pkg::tpc_ctl_type  ctl,
  input  wire logic                  in_valid,
  input  wire tpc_pkg::tpc_beat_type in_beat,
  output logic                       in_ready,
  output tpc_pkg::tpc_line_type      line_q,
  output logic                       test_mode_q
);
  import tpc_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_DATA  = 6'b000010,
    ST_FCS   = 6'b000100,
    ST_TERM  = 6'b001000,
    ST_GAP   = 6'b010000,
    ST_SPARE = 6'b100000
  } tpc_state_type;

  tpc_state_type state_q, state_d;
  tpc_line_type  line_d;
  logic          test_mode_d;
  logic          fcs_on_q, fcs_on_d;
  logic [1:0]    fcs_idx_q, fcs_idx_d;
  logic [3:0]    gap_q, gap_d;
  logic [57:0]   scr_q, scr_d;
  logic [7:0]    scr_byte;
  logic          scr_adv;
  logic [31:0]   crc_q;
  logic          crc_init;
  logic          crc_en;
  logic [3:0]    ipg_clamped;
  logic [3:0]    idle_count;
  logic [31:0]   fcs_word;

  // ------------------------------------------------------------
  // frame check accumulator
  // ------------------------------------------------------------
  tpc_crc u_crc (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .init     (crc_init),
    .en       (crc_en),
    .data     (in_beat.data),
    .crc_q    (crc_q)
  );

  assign fcs_word = ~crc_q;

  // ------------------------------------------------------------
  // gap length
  // ------------------------------------------------------------
  // idles after the terminate byte; small settings add none
  always_comb begin
    ipg_clamped = (ctl.ipg_bytes > IPG_MAX) ? IPG_MAX : ctl.ipg_bytes;
    if (ctl.ipg_bytes < IPG_MIN) begin
      idle_count = '0;
    end else begin
      idle_count = ipg_clamped - IPG_TERM;
    end
  end

  // stream handshake: bytes are taken only inside a packet
  assign in_ready = (state_q == ST_DATA);
  assign crc_en   = (state_q == ST_DATA) && in_valid;

  // ------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------
  // next state, line byte and latched per-packet settings
  always_comb begin
    state_d     = state_q;
    line_d      = '{ctrl: 1'b1, data: CODE_IDLE};
    test_mode_d = test_mode_q;
    fcs_on_d    = fcs_on_q;
    crc_init    = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        test_mode_d = ctl.test_pattern;
        if (ctl.test_pattern) begin
          line_d = '{ctrl: 1'b0, data: scr_byte};
        end else if (ctl.tx_gate && in_valid) begin
          line_d   = '{ctrl: 1'b1, data: CODE_START};
          fcs_on_d = ctl.fcs_append;
          crc_init = 1'b1;
          state_d  = ST_DATA;
        end
      end
      ST_DATA: begin
        if (in_valid) begin
          line_d = '{ctrl: 1'b0, data: in_beat.data};
          if (in_beat.last) begin
            state_d = fcs_on_q ? ST_FCS : ST_TERM;
          end
        end else begin
          line_d = '{ctrl: 1'b1, data: CODE_ERROR}; // source starved mid-packet
        end
      end
      ST_FCS: begin
        line_d = '{ctrl: 1'b0, data: fcs_word[{fcs_idx_q, 3'b000} +: 8]};
        if (fcs_idx_q == FCS_LAST) begin
          state_d = ST_TERM;
        end
      end
      ST_TERM: begin
        line_d  = '{ctrl: 1'b1, data: CODE_TERM};
        state_d = (idle_count == '0) ? ST_IDLE : ST_GAP;
      end
      ST_GAP: begin
        // last idle of the gap: the next cycle may already start a packet
        if (gap_q == 4'h1) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // sequencer registers; the line shows idles through reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      line_q      <= '{ctrl: 1'b1, data: CODE_IDLE};
      test_mode_q <= 1'b0;
      fcs_on_q    <= 1'b0;
    end else begin
      state_q     <= state_d;
      line_q      <= line_d;
      test_mode_q <= test_mode_d;
      fcs_on_q    <= fcs_on_d;
    end
  end

  // ------------------------------------------------------------
  // test pattern scrambler
  // ------------------------------------------------------------
  // steps only while a test byte is sent, so the pattern always
  // restarts from the same seed after a reset
  assign scr_adv = (state_q == ST_IDLE) && ctl.test_pattern;

  // scramble one idle byte, lsb first, with the output fed back
  always_comb begin
    logic [57:0] nxt;
    logic        s;
    nxt      = scr_q;
    s        = 1'b0;
    scr_byte = '0;
    for (int i = 0; i < 8; i++) begin
      s           = CODE_IDLE[i] ^ nxt[SCR_TAP_A] ^ nxt[SCR_TAP_B];
      scr_byte[i] = s;
      nxt         = {nxt[56:0], s};
    end
    scr_d = scr_adv ? nxt : scr_q;
  end

  // scrambler register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scr_q <= SCR_INIT;
    end else begin
      scr_q <= scr_d;
    end
  end

  // ------------------------------------------------------------
  // fcs byte index
  // ------------------------------------------------------------
  // held at zero through the payload so the first fcs byte is byte 0
  always_comb begin
    fcs_idx_d = fcs_idx_q;
    if (state_q == ST_DATA) begin
      fcs_idx_d = '0;
    end else if (state_q == ST_FCS) begin
      fcs_idx_d = fcs_idx_q + 2'h1;
    end
  end

  // fcs index register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fcs_idx_q <= '0;
    end else begin
      fcs_idx_q <= fcs_idx_d;
    end
  end

  // ------------------------------------------------------------
  // gap countdown
  // ------------------------------------------------------------
  // loaded at the terminate byte, then one idle byte per cycle; the
  // terminate byte itself is the first byte of the gap
  always_comb begin
    gap_d = gap_q;
    if (state_q == ST_TERM) begin
      gap_d = idle_count;
    end else if (state_q == ST_GAP) begin
      gap_d = gap_q - 4'h1;
    end
  end

  // gap register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_d;
    end
  end
endmodule

// File: dv/tb.sv
// Purpose: self-checking bench for tpc_top
// Assumes: tpc_src supplies the stream
// Notes:   fcs select changes only under reset
`timescale 1ns/1ps
module tb;
  import tpc_pkg::*;
  logic         core_clk, sys_rst, en, in_valid, in_ready, test_mode_q, hit;
  logic [3:0]   len;
  tpc_ctl_type  ctl;
  tpc_beat_type in_beat;
  tpc_line_type line_q;
  int           error_cnt, comparisons, run, gap_n, body, gap;
  logic [31:0]  tail, fcs_seen;
  logic [57:0]  scr;
  logic [7:0]   sb;
  // ipg, fcs, len, body bytes, gap bytes
  int rows [6][5] = '{'{0,1,2,6,1}, '{7,0,3,3,1}, '{8,1,1,5,8}, '{10,0,4,4,10}, '{12,1,2,6,12}, '{15,0,5,5,12}};
  tpc_top u_dut (.core_clk, .sys_rst, .ctl, .in_valid, .in_beat, .in_ready, .line_q, .test_mode_q);
  tpc_src u_src (.core_clk, .sys_rst, .en, .len, .in_ready, .in_valid, .in_beat);
  // core clock
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  // frame body and gap lengths seen on the line
  // the gap counts the terminate byte; the last four data bytes before it are the fcs
  always @(posedge core_clk) begin
    run++;
    gap_n++;
    if (line_q.ctrl === 1'b0) begin
      tail = {line_q.data, tail[31:8]};
    end
    if (line_q === {1'b1, CODE_START}) begin
      gap = gap_n;
      run = 0;
    end
    if (line_q === {1'b1, CODE_TERM}) begin
      body     = run - 1;
      gap_n    = 0;
      fcs_seen = tail;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, want);
    end
  endtask
  // reference fcs over the source payload {A, index}, lsb first, inverted
  function automatic logic [31:0] crc_ref(input int n);
    logic [31:0] c;
    logic [7:0]  b;
    c = CRC_INIT;
    for (int k = 0; k < n; k++) begin
      b = {4'hA, k[3:0]};
      for (int j = 0; j < 8; j++) begin
        c = (c[0] ^ b[j]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    return ~c;
  endfunction
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // bounded wait for a line code; a wrong outcome ends the run
  task automatic await(input tpc_line_type c, input logic want);
    hit = 0;
    for (int k = 0; k < 60 && !hit; k++) begin
      tick(1);
      hit = (line_q === c);
    end
    check(hit, want);
    if (hit !== want) results();
  endtask
  task automatic boot(input logic [6:0] c, input int n, input logic [3:0] l);
    {sys_rst, en, ctl, len} = {2'b10, c, l};
    tick(n);
    {sys_rst, en} = 2'b01;
  endtask
  // main sequence
  initial begin
    {error_cnt, comparisons, run, gap_n, body, gap} = '0;
    boot(7'h0C, 20, 4'h2);
    check(line_q, {1'b1, CODE_IDLE});
    check(in_ready, 0);
    $display("reset done");
    foreach (rows[i]) begin
      boot({2'b01, rows[i][1][0], rows[i][0][3:0]}, 1, rows[i][2][3:0]);
      await({1'b1, CODE_START}, 1);
      await({1'b1, CODE_TERM}, 1);
      await({1'b1, CODE_START}, 1);
      tick(1);
      check(body, rows[i][3]);
      check(gap, rows[i][4]);
      if (rows[i][1] != 0) check(fcs_seen, crc_ref(rows[i][2]));
      $display("row %0d done", i);
    end
    boot(7'h38, 1, 4'h6);
    await({1'b1, CODE_START}, 1);
    ctl.tx_gate = 0;
    await({1'b1, CODE_TERM}, 1);
    tick(1);
    check(body, 10);
    await({1'b1, CODE_START}, 0);
    $display("gate test done");
    boot(7'h30, 1, 4'h4);
    await({1'b1, CODE_START}, 1);
    tick(1);
    en = 0;
    tick(1);
    check(line_q, {1'b1, CODE_ERROR});
    en = 1;
    await({1'b1, CODE_TERM}, 1);
    $display("underrun test done");
    boot(7'h68, 1, 4'h2);
    scr = SCR_INIT;
    for (int k = 0; k < 12; k++) begin
      for (int j = 0; j < 8; j++) begin
        sb[j] = CODE_IDLE[j] ^ scr[SCR_TAP_A] ^ scr[SCR_TAP_B];
        scr   = {scr[56:0], sb[j]};
      end
      tick(1);
      check(line_q, {1'b0, sb});
    end
    await({1'b1, CODE_START}, 0);
    check(test_mode_q, 1);
    check(line_q.ctrl, 0);
    $display("test mode done");
    results();
  end
endmodule

// File: dv/tpc_props.sv
// Purpose: port assertions for tpc_top
// Assumes: tpc_pkg compiled first
// Notes:   gap_q counts line bytes from the last terminate, that byte included
`timescale 1ns/1ps
module tpc_props
  import tpc_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire tpc_pkg::tpc_ctl_type  ctl,
  input wire logic                  in_valid,
  input wire tpc_pkg::tpc_beat_type in_beat,
  input wire logic                  in_ready,
  input wire tpc_pkg::tpc_line_type line_q,
  input wire logic                  test_mode_q
);
  logic [3:0] gap_q, gap_d, need;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // saturating byte count since terminate
  always_comb begin
    gap_d = (gap_q == 4'hF) ? gap_q : gap_q + 4'h1;
    if (line_q == {1'b1, CODE_TERM}) gap_d = 4'h1;
  end
  always_ff @(posedge core_clk) gap_q <= sys_rst ? 4'hF : gap_d;
  // idles owed by the gap setting, terminate included
  assign need = (ctl.ipg_bytes < IPG_MIN) ? 4'h1 : (ctl.ipg_bytes > IPG_MAX) ? IPG_MAX : ctl.ipg_bytes;
  sequence s_last; in_ready && in_valid && in_beat.last; endsequence
  sequence s_fcs; !line_q.ctrl [*4]; endsequence
  chk_gate_block: assert property (!in_ready && !ctl.tx_gate |=> !in_ready) else $error("start with gate low");
  chk_byte_pass: assert property (in_ready && in_valid |=> line_q == {1'b0, $past(in_beat.data)})
    else $error("payload byte lost");
  chk_start_code: assert property ($rose(in_ready) |-> line_q == {1'b1, CODE_START}) else $error("no start");
  chk_gate_hold: assert property (in_ready && !(in_valid && in_beat.last) |=> in_ready) else $error("cut");
  chk_last_drop: assert property (s_last |=> !in_ready) else $error("ready after last");
  chk_test_quiet: assert property (test_mode_q |-> !in_ready) else $error("traffic in test mode");
  chk_fcs_off: assert property (s_last ##0 !ctl.fcs_append |-> ##2 line_q == {1'b1, CODE_TERM})
    else $error("fcs added");
  chk_fcs_on: assert property (s_last ##0 ctl.fcs_append |-> ##2 s_fcs ##1 line_q == {1'b1, CODE_TERM})
    else $error("fcs missing");
  chk_gap_min: assert property (line_q == {1'b1, CODE_START} |-> gap_q >= need) else $error("gap short");
endmodule
bind tpc_top tpc_props u_props (.core_clk, .sys_rst, .ctl, .in_valid, .in_beat, .in_ready, .line_q, .test_mode_q);

// File: dv/tpc_src.sv
// Purpose: user stream source for tpc_top
// Assumes: packets of len bytes back to back while en is high
// Notes:   released data shows inverted index, never a stale byte
`timescale 1ns/1ps
module tpc_src
  import tpc_pkg::*;
(
  input wire logic           core_clk,
  input wire logic           sys_rst,
  input wire logic           en,
  input wire logic [3:0]     len,
  input wire logic           in_ready,
  output logic               in_valid,
  output tpc_pkg::tpc_beat_type in_beat
);
  logic [3:0] idx_q, idx_d;
  // advance only when the byte is taken
  always_comb begin
    idx_d = idx_q;
    if (in_ready && in_valid) idx_d = in_beat.last ? 4'h0 : idx_q + 4'h1;
  end
  always_ff @(posedge core_clk) idx_q <= sys_rst ? 4'h0 : idx_d;
  // byte held steady until taken
  assign in_valid = en;
  assign in_beat = '{data: en ? {4'hA, idx_q} : {4'h5, ~idx_q}, last: idx_q == len - 4'h1};
endmodule
